// File: hw/epid_pkg.sv
// constants for the external pin interrupt detector
package epid_pkg;
  // register map
  localparam logic [11:0] STATUS_CONTROL_OFFSET = 12'h000;
  // field positions
  localparam int MODE_BIT   = 0;
  localparam int IE_BIT     = 1;
  localparam int ACK_BIT    = 2;
  localparam int FLAG_BIT   = 3;
  localparam int PE_BIT     = 4;
  localparam int EDGE_BIT   = 5;
  localparam int PDD_BIT    = 6;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic       SYNC_RESET = 1'b1;
endpackage

// File: hw/epid_sync.sv
// two-flop synchroniser for the request pin
`timescale 1ns/1ps
module epid_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // data
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // first flop only feeds the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= epid_pkg::SYNC_RESET;
      q      <= epid_pkg::SYNC_RESET;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: hw/epid_top.sv
// external pin interrupt detector with apb status and control register
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module epid_top (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // request pin
  input  wire logic        irq_pin,
  // pad control
  output logic             pull_enable,
  output logic             pull_down,
  // core request
  output logic             core_irq
);
  logic [6:0] ctrl_r;
  logic       flag_r;
  logic       pin_s;
  logic       pin_prev_r;
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic       ack;
  logic       act_now;
  logic       act_prev;
  logic       edge_ev;
  logic       level_ev;
  logic       set_ev;
  logic [7:0] rd_val;

  logic pe;
  logic pol;
  logic mode;
  logic ie;
  logic pdd;
  assign pe   = ctrl_r[epid_pkg::PE_BIT];
  assign pol  = ctrl_r[epid_pkg::EDGE_BIT];
  assign mode = ctrl_r[epid_pkg::MODE_BIT];
  assign ie   = ctrl_r[epid_pkg::IE_BIT];
  assign pdd  = ctrl_r[epid_pkg::PDD_BIT];

  // active level of a sample under the chosen polarity
  function automatic logic is_active(input logic lvl, input logic rising);
    is_active = rising ? lvl : ~lvl;
  endfunction

  // pin synchroniser
  epid_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (irq_pin),
    .q       (pin_s)
  );

  // apb decode, zero wait states
  assign hit     = (paddr == epid_pkg::STATUS_CONTROL_OFFSET);
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign rd_en   = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // control bits, flag and ack bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= epid_pkg::CTRL_RESET[6:0];
    end else if (wr_en && hit) begin
      ctrl_r[epid_pkg::MODE_BIT] <= pwdata[epid_pkg::MODE_BIT];
      ctrl_r[epid_pkg::IE_BIT]   <= pwdata[epid_pkg::IE_BIT];
      ctrl_r[epid_pkg::PE_BIT]   <= pwdata[epid_pkg::PE_BIT];
      ctrl_r[epid_pkg::EDGE_BIT] <= pwdata[epid_pkg::EDGE_BIT];
      ctrl_r[epid_pkg::PDD_BIT]  <= pwdata[epid_pkg::PDD_BIT];
    end
  end

  // previous synchronised sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= epid_pkg::SYNC_RESET;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  // event detection
  assign act_now  = is_active(pin_s, pol);
  assign act_prev = is_active(pin_prev_r, pol);
  assign edge_ev  = act_now && !act_prev;
  assign level_ev = mode && act_now;
  assign set_ev   = pe && (edge_ev || level_ev);
  assign ack      = wr_en && hit && pwdata[epid_pkg::ACK_BIT];

  // event flag, set wins over acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (set_ev) begin
      flag_r <= 1'b1;
    end else if (ack) begin
      flag_r <= 1'b0;
    end
  end

  // read data, ack reads 0
  always_comb begin
    rd_val = 8'h00;
    rd_val[epid_pkg::MODE_BIT] = mode;
    rd_val[epid_pkg::IE_BIT]   = ie;
    rd_val[epid_pkg::FLAG_BIT] = flag_r;
    rd_val[epid_pkg::PE_BIT]   = pe;
    rd_val[epid_pkg::EDGE_BIT] = pol;
    rd_val[epid_pkg::PDD_BIT]  = pdd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // pad pull control and core request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_enable <= 1'b0;
      pull_down   <= 1'b0;
      core_irq    <= 1'b0;
    end else begin
      pull_enable <= pe && !pdd;
      pull_down   <= pe && pol;
      core_irq    <= ie && (set_ev || (flag_r && !ack));
    end
  end

  // assertions
  property p_ack_clears;
    @(posedge pclk) disable iff (!presetn)
      (ack && !set_ev && flag_r) |=> !flag_r;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear flag");

  property p_level_holds;
    @(posedge pclk) disable iff (!presetn)
      (pe && mode && act_now) |=> flag_r;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("flag cleared at active level");

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
      (!pe && !flag_r && !ack) |=> !flag_r;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set while disabled");

  sequence s_edge_seen;
    pe && !act_prev && act_now;
  endsequence
  property p_edge_sets;
    @(posedge pclk) disable iff (!presetn)
      s_edge_seen |=> flag_r;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      core_irq == ($past(ie) && flag_r);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("request mismatch");

  property p_irq_flag;
    @(posedge pclk) disable iff (!presetn)
      (flag_r && ie) |=> (core_irq || !flag_r);
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("request missing with flag");

  property p_pull_dir;
    @(posedge pclk) disable iff (!presetn)
      (pe && pol) ##1 (pe && pol) |-> pull_down;
  endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pulldown not selected");

  property p_pull_off;
    @(posedge pclk) disable iff (!presetn)
      (pe && pdd) ##1 (pe && pdd) |-> !pull_enable;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull not disabled");

  property p_ack_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && !penable) |=> !prdata[epid_pkg::ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as 1");

  // polling mode never raises the core request
  property p_irq_poll;
    @(posedge pclk) disable iff (!presetn)
      !ie |=> !core_irq;
  endproperty
  a_irq_poll: assert property (p_irq_poll) else $error("request raised while polling");

  // steady pin in edge-only mode leaves a clear flag clear
  property p_edge_only;
    @(posedge pclk) disable iff (!presetn)
      (!mode && !flag_r && (pin_s == pin_prev_r)) |=> !flag_r;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("flag set without an edge");

  // falling polarity catches a high to low step
  property p_fall_sets;
    @(posedge pclk) disable iff (!presetn)
      (pe && !pol && pin_prev_r && !pin_s) |=> flag_r;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge did not set flag");

  // read data carries the flag of the setup cycle
  property p_flag_reads;
    @(posedge pclk) disable iff (!presetn)
      (psel && !pwrite && !penable && (paddr == epid_pkg::STATUS_CONTROL_OFFSET))
        |=> (prdata[epid_pkg::FLAG_BIT] == $past(flag_r));
  endproperty
  a_flag_reads: assert property (p_flag_reads) else $error("flag not returned on read");

  // a mapped write sets the pin enable from the bus
  property p_write_lands;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && pstrb[0] && (paddr == epid_pkg::STATUS_CONTROL_OFFSET))
        |=> (pe == $past(pwdata[epid_pkg::PE_BIT]));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("pin enable not written");
endmodule

// File: tb/epid_pin_model.sv
// model of the external circuitry on the request pin
`timescale 1ns/1ps
module epid_pin_model (
  // clock
  input  wire logic pclk,
  // bench control
  input  wire logic drive,
  input  wire logic level,
  // pad control from the block
  input  wire logic pull_enable,
  input  wire logic pull_down,
  // request pin
  output logic      irq_pin
);
  logic float_r;
  // an undriven, unpulled pin toggles every cycle
  always_ff @(posedge pclk) float_r <= (float_r !== 1'b1);
  // driver wins, else the pad pull, else the wandering level
  always_comb begin
    if (drive) irq_pin = level;
    else if (pull_enable) irq_pin = ~pull_down;
    else irq_pin = float_r;
  end
endmodule

// File: tb/tb_epid_top.sv
// directed testbench for the external pin interrupt detector
`timescale 1ns/1ps
module tb_epid_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq_pin, pull_enable, pull_down, core_irq, er, drv, lvl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          errors = 0;
  int          num_checks = 0;
  epid_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin(irq_pin), .pull_enable(pull_enable), .pull_down(pull_down), .core_irq(core_irq));
  epid_pin_model u_pin (.pclk(pclk), .drive(drv), .level(lvl), .pull_enable(pull_enable),
    .pull_down(pull_down), .irq_pin(irq_pin));
  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // verdict and end of run
  task test_done;
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // compare seen against expected
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, read data and error kept in rd and er
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // write unless d is zero, let the pin settle, read back and compare
  task wr_pin(input logic [7:0] d, input logic l, input logic [7:0] e);
    if (d != 8'h00) apb(1'b1, 12'h000, d);
    lvl <= l;
    repeat (6) @(posedge pclk);
    apb(1'b0, 12'h000, 8'h00);
    chk("register", rd, {24'h000000, e});
  endtask
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; drv = 1'b1; lvl = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wr_pin(8'h00, 1'b0, 8'h00);
    wr_pin(8'h7F, 1'b0, 8'h73);
    chk("pull_enable", pull_enable, 1'b0);
    wr_pin(8'h30, 1'b0, 8'h30);
    chk("pull_down", {pull_enable, pull_down}, 2'b11);
    wr_pin(8'h10, 1'b0, 8'h10);
    chk("pull_down", {pull_enable, pull_down}, 2'b10);
    wr_pin(8'h02, 1'b1, 8'h02);
    wr_pin(8'h00, 1'b0, 8'h02);
    wr_pin(8'h12, 1'b1, 8'h12);
    wr_pin(8'h00, 1'b0, 8'h1A);
    chk("core_irq", core_irq, 1'b1);
    wr_pin(8'h12, 1'b0, 8'h1A);
    wr_pin(8'h16, 1'b0, 8'h12);
    chk("core_irq", core_irq, 1'b0);
    wr_pin(8'h10, 1'b1, 8'h10);
    wr_pin(8'h00, 1'b0, 8'h18);
    chk("core_irq", core_irq, 1'b0);
    wr_pin(8'h13, 1'b0, 8'h1B);
    wr_pin(8'h17, 1'b0, 8'h1B);
    wr_pin(8'h17, 1'b1, 8'h1B);
    wr_pin(8'h17, 1'b1, 8'h13);
    wr_pin(8'h32, 1'b0, 8'h32);
    wr_pin(8'h00, 1'b1, 8'h3A);
    drv <= 1'b0;
    wr_pin(8'h36, 1'b1, 8'h32);
    wr_pin(8'h12, 1'b1, 8'h12);
    apb(1'b1, 12'h004, 8'h1F);
    chk("pslverr", er, 1'b1);
    apb(1'b0, 12'h004, 8'h00);
    chk("pslverr", er, 1'b1);
    chk("unmapped", rd, 32'h00000000);
    wr_pin(8'h00, 1'b1, 8'h12);
    test_done();
  end
endmodule
